/* File: common/lpd_consts.vh */
`ifndef LPD_CONSTS_VH
`define LPD_CONSTS_VH

// ------------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------------
`define LPD_CLK_KHZ      25000
`define LPD_TSI_MS       16
`define LPD_TSI_CYC      (`LPD_TSI_MS * `LPD_CLK_KHZ)
`define LPD_TREFI_NS     7800
`define LPD_REFI_CYC     ((`LPD_TREFI_NS * `LPD_CLK_KHZ) / 1000000)
`define LPD_RL_DEF       3
`define LPD_BURST_LAST   2'h3
`define LPD_DENSITY_DEF  1024
`define LPD_SEG_MIN_MB   1024

// ------------------------------------------------------------------
// mode register addresses
// ------------------------------------------------------------------
`define LPD_MA_TEMP      8'h04
`define LPD_MA_BANK_MASK 8'h10
`define LPD_MA_SEG_MASK  8'h11
`define LPD_MA_CAL_A     8'h20
`define LPD_MA_CAL_B     8'h28
`define LPD_MA_RESET     8'h3F

// ------------------------------------------------------------------
// command codes on ca[3:0] (self refresh on ca[2:0]), cs_n low
// ------------------------------------------------------------------
`define LPD_CMD_MRR      4'h8
`define LPD_CMD_MRW      4'h0
`define LPD_CMD_SREF     3'h4

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define LPD_BANK_MASK_RST 8'h00
`define LPD_SEG_MASK_RST  8'h00
`define LPD_TEMP_RST      3'h3
`define LPD_PIN_RST       16'h0C00

`endif

/* File: hw/lpd_mrr_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "lpd_consts.vh"

module lpd_mrr_core #(
   parameter        DQ_W       = 16,
   parameter [3:0]  RL         = `LPD_RL_DEF,
   parameter        DENSITY_MB = `LPD_DENSITY_DEF,
   parameter [19:0] TSI_CYC    = `LPD_TSI_CYC,
   parameter [19:0] REFI_CYC   = `LPD_REFI_CYC
) (
   // system
   input  wire              clk,
   input  wire              srst,
   input  wire              ce,
   // command and address link
   input  wire              ck,
   input  wire              cke,
   input  wire              cs_n,
   input  wire [9:0]        ca,
   // data lanes and strobes
   output wire [DQ_W-1:0]   dq_o,
   output wire              dq_oe_n,
   output wire [DQ_W/8-1:0] dqs_o,
   output wire              dqs_oe_n,
   // temperature sensor
   input  wire [2:0]        temp_code,
   // internal refresh and power state
   output wire              ref_pulse,
   output wire [2:0]        ref_bank,
   output wire [2:0]        ref_seg,
   output wire              self_ref,
   output wire              pwr_down
);

   // ---------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------
   localparam       NL       = DQ_W / 8;
   localparam [0:0] SEG_EN   = (DENSITY_MB >= `LPD_SEG_MIN_MB);
   localparam [2:0] BANK_LAST = SEG_EN ? 3'h7 : 3'h3;
   localparam [3:0] RL_LAST  = RL - 4'h1;

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_MRR_F = 3'h1;
   localparam [2:0] ST_MRW_F = 3'h2;
   localparam [2:0] ST_WAIT  = 3'h3;
   localparam [2:0] ST_BURST = 3'h4;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // command match on cs_n and the low ca bits
   function cmd_is;
      input       csn;
      input [3:0] ca_lo;
      input [3:0] code;
      begin
         cmd_is = ~csn & (ca_lo == code);
      end
   endfunction

   // one data word for a beat of a mode register read
   function [DQ_W-1:0] beat_word;
      input [7:0] ma;
      input [1:0] beat;
      input [7:0] rd;
      begin
         if (ma == `LPD_MA_CAL_A) begin
            beat_word = {DQ_W{~beat[0]}};
         end else if (ma == `LPD_MA_CAL_B) begin
            beat_word = {DQ_W{beat[1]}};
         end else if (beat == 2'h0) begin
            beat_word = {{(DQ_W-8){1'b0}}, rd};
         end else begin
            beat_word = {DQ_W{1'b0}};
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   wire [15:0] pin_raw;
   reg  [15:0] pin_s1_reg;
   reg  [15:0] pin_s2_reg;
   reg         ck_d_reg;

   assign pin_raw = {temp_code, ck, cke, cs_n, ca};

   // two flops on every link pin, then one more on ck for edges
   always @(posedge clk) begin
      if (srst) begin
         pin_s1_reg <= `LPD_PIN_RST; // idle levels: cs_n and cke high
         pin_s2_reg <= `LPD_PIN_RST;
         ck_d_reg   <= 1'b0;
      end else if (ce) begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         ck_d_reg   <= pin_s2_reg[12];
      end
   end

   wire [9:0] ca_s     = pin_s2_reg[9:0];
   wire       cs_n_s   = pin_s2_reg[10];
   wire       cke_s    = pin_s2_reg[11];
   wire       ck_s     = pin_s2_reg[12];
   wire [2:0] temp_s   = pin_s2_reg[15:13];
   wire       ck_rise  = ck_s & ~ck_d_reg;
   wire       ck_fall  = ~ck_s & ck_d_reg;

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire is_mrr  = cmd_is(cs_n_s, ca_s[3:0], `LPD_CMD_MRR);
   wire is_mrw  = cmd_is(cs_n_s, ca_s[3:0], `LPD_CMD_MRW);
   wire is_sref = ~cs_n_s & (ca_s[2:0] == `LPD_CMD_SREF);

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   reg [2:0]      st_reg;
   reg [5:0]      ma_hi_reg;
   reg [7:0]      ma_reg;
   reg [3:0]      lat_reg;
   reg [1:0]      beat_reg;
   reg [DQ_W-1:0] dq_reg;
   reg [NL-1:0]   dqs_reg;
   reg            drive_reg;
   reg            sr_reg;
   reg            pd_reg;
   reg            wake_reg;
   reg [7:0]      refresh_bank_mask_reg;
   reg [7:0]      refresh_segment_mask_reg;
   reg [2:0]      device_temperature_reg;
   reg [7:0]      rd_byte;

   // readable contents; the mask registers are write only
   always @* begin
      if (ma_reg == `LPD_MA_TEMP) begin
         rd_byte = {5'h00, device_temperature_reg};
      end else begin
         rd_byte = 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // command, mode register and read burst sequencer
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         st_reg                   <= ST_IDLE;
         ma_hi_reg                <= 6'h00;
         ma_reg                   <= 8'h00;
         lat_reg                  <= 4'h0;
         beat_reg                 <= 2'h0;
         dq_reg                   <= {DQ_W{1'b0}};
         dqs_reg                  <= {NL{1'b0}};
         drive_reg                <= 1'b0;
         sr_reg                   <= 1'b0;
         pd_reg                   <= 1'b0;
         wake_reg                 <= 1'b0;
         refresh_bank_mask_reg    <= `LPD_BANK_MASK_RST;
         refresh_segment_mask_reg <= `LPD_SEG_MASK_RST;
      end else if (ce) begin
         wake_reg <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               if (ck_rise & (sr_reg | pd_reg)) begin
                  // low power exit on cke high
                  if (cke_s) begin
                     sr_reg   <= 1'b0;
                     pd_reg   <= 1'b0;
                     wake_reg <= 1'b1;
                  end
               end else if (ck_rise & ~cke_s) begin
                  if (is_sref) begin
                     sr_reg <= 1'b1;
                  end else if (cs_n_s) begin
                     pd_reg <= 1'b1;
                  end
               end else if (ck_rise & is_mrr) begin
                  ma_hi_reg <= ca_s[9:4];
                  st_reg    <= ST_MRR_F;
               end else if (ck_rise & is_mrw) begin
                  ma_hi_reg <= ca_s[9:4];
                  st_reg    <= ST_MRW_F;
               end
            end
            ST_MRR_F: begin
               if (ck_fall) begin
                  ma_reg  <= {ma_hi_reg, ca_s[1:0]};
                  lat_reg <= 4'h0;
                  st_reg  <= ST_WAIT;
               end
            end
            ST_MRW_F: begin
               if (ck_fall) begin
                  st_reg <= ST_IDLE;
                  case ({ma_hi_reg, ca_s[1:0]})
                     `LPD_MA_BANK_MASK: begin
                        refresh_bank_mask_reg <= ca_s[9:2];
                     end
                     `LPD_MA_SEG_MASK: begin
                        if (SEG_EN) begin
                           refresh_segment_mask_reg <= ca_s[9:2];
                        end
                     end
                     `LPD_MA_RESET: begin
                        refresh_bank_mask_reg    <= `LPD_BANK_MASK_RST;
                        refresh_segment_mask_reg <= `LPD_SEG_MASK_RST;
                     end
                     default: begin
                        st_reg <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_WAIT: begin
               // commands are ignored until the burst is out
               if (ck_rise) begin
                  lat_reg <= lat_reg + 4'h1;
                  if (lat_reg == RL_LAST) begin
                     beat_reg  <= 2'h0;
                     dq_reg    <= beat_word(ma_reg, 2'h0, rd_byte);
                     dqs_reg   <= {NL{1'b1}};
                     drive_reg <= 1'b1;
                     st_reg    <= ST_BURST;
                  end
               end
            end
            ST_BURST: begin
               // one beat per ck edge, four beats, not interruptible
               if (ck_rise | ck_fall) begin
                  if (beat_reg == `LPD_BURST_LAST) begin
                     drive_reg <= 1'b0;
                     dqs_reg   <= {NL{1'b0}};
                     dq_reg    <= {DQ_W{1'b0}};
                     st_reg    <= ST_IDLE;
                  end else begin
                     beat_reg <= beat_reg + 2'h1;
                     dq_reg   <= beat_word(ma_reg, beat_reg + 2'h1, rd_byte);
                     dqs_reg  <= {NL{beat_reg[0]}};
                  end
               end
            end
            default: begin
               st_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // temperature sensor sampling
   // ---------------------------------------------------------------
   reg [19:0] tsi_cnt_reg;

   // update on the interval timer and on every low power exit
   always @(posedge clk) begin
      if (srst) begin
         tsi_cnt_reg            <= 20'h00000;
         device_temperature_reg <= `LPD_TEMP_RST;
      end else if (ce) begin
         if (wake_reg | (tsi_cnt_reg == TSI_CYC - 20'h00001)) begin
            tsi_cnt_reg            <= 20'h00000;
            device_temperature_reg <= temp_s;
         end else begin
            tsi_cnt_reg <= tsi_cnt_reg + 20'h00001;
         end
      end
   end

   // ---------------------------------------------------------------
   // self refresh walker with bank and segment masking
   // ---------------------------------------------------------------
   reg [19:0] refi_cnt_reg;
   reg [2:0]  bank_reg;
   reg [2:0]  seg_reg;
   reg        ref_pulse_reg;
   reg [2:0]  ref_bank_reg;
   reg [2:0]  ref_seg_reg;

   wire bank_ok = ~refresh_bank_mask_reg[bank_reg];
   wire seg_ok  = ~SEG_EN | ~refresh_segment_mask_reg[seg_reg];
   wire ref_ok  = bank_ok & seg_ok;

   // walk every bank for each segment, one slot per refresh interval
   always @(posedge clk) begin
      if (srst) begin
         refi_cnt_reg  <= 20'h00000;
         bank_reg      <= 3'h0;
         seg_reg       <= 3'h0;
         ref_pulse_reg <= 1'b0;
         ref_bank_reg  <= 3'h0;
         ref_seg_reg   <= 3'h0;
      end else if (ce) begin
         ref_pulse_reg <= 1'b0;
         if (!sr_reg) begin
            refi_cnt_reg <= 20'h00000;
         end else if (refi_cnt_reg == REFI_CYC - 20'h00001) begin
            refi_cnt_reg  <= 20'h00000;
            ref_pulse_reg <= ref_ok;
            ref_bank_reg  <= bank_reg;
            ref_seg_reg   <= seg_reg;
            if (bank_reg == BANK_LAST) begin
               bank_reg <= 3'h0;
               seg_reg  <= seg_reg + 3'h1;
            end else begin
               bank_reg <= bank_reg + 3'h1;
            end
         end else begin
            refi_cnt_reg <= refi_cnt_reg + 20'h00001;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign dq_o      = dq_reg;
   assign dq_oe_n   = ~drive_reg;
   assign dqs_o     = dqs_reg;
   assign dqs_oe_n  = ~drive_reg;
   assign ref_pulse = ref_pulse_reg;
   assign ref_bank  = ref_bank_reg;
   assign ref_seg   = ref_seg_reg;
   assign self_ref  = sr_reg;
   assign pwr_down  = pd_reg;

endmodule // lpd_mrr_core

`default_nettype wire

/* File: testbench/lpd_mrr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// read burst and refresh checks at the ports
// ------------------------------------------
module lpd_mrr_checker #(
   parameter        DQ_W     = 16,
   parameter [19:0] REFI_CYC = 8
) (
   // system
   input wire              clk,
   input wire              srst,
   // link
   input wire              ck,
   input wire              cke,
   input wire              cs_n,
   input wire [9:0]        ca,
   // data
   input wire [DQ_W-1:0]   dq_o,
   input wire              dq_oe_n,
   input wire [DQ_W/8-1:0] dqs_o,
   input wire              dqs_oe_n,
   // refresh
   input wire              ref_pulse,
   input wire              self_ref
);
   reg [7:0]  oe_cnt_reg;
   reg [19:0] gap_reg;
   reg        ck_q_reg;
   reg [7:0]  age_reg;
   wire       mrr_seen = ck && !ck_q_reg && cke && !cs_n && (ca[3:0] == 4'h8) && dq_oe_n;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // burst length, refresh gap and cycles since a mode read command
   always @(posedge clk) begin
      oe_cnt_reg <= (srst || dq_oe_n) ? 8'h00 : oe_cnt_reg + 8'h01;
      gap_reg    <= (srst || ref_pulse) ? 20'h00000 : gap_reg + 20'h00001;
      ck_q_reg   <= ck;
      age_reg    <= (srst || !dq_oe_n) ? 8'h00 : mrr_seen ? 8'h01 :
                    (age_reg != 8'h00 && age_reg != 8'hFF) ? age_reg + 8'h01 : age_reg;
   end
   sequence mrr_cmd;
      $rose(ck) && cke && !cs_n && ca[3:0] == 4'h8 && dq_oe_n;
   endsequence
   sequence burst_start;
      ##[20:29] $fell(dq_oe_n);
   endsequence
   a_mrr_latency: assert property (mrr_cmd |-> burst_start)
      else $error("read burst not at read latency");
   a_burst_early: assert property ($fell(dq_oe_n) |-> age_reg >= 8'h14)
      else $error("read burst before read latency");
   a_burst_len: assert property ($rose(dq_oe_n) |-> oe_cnt_reg == 8'h10)
      else $error("read burst not four beats");
   a_oe_pair: assert property (dq_oe_n == dqs_oe_n)
      else $error("strobe enable differs from data enable");
   a_strobe_first: assert property ($fell(dqs_oe_n) |-> &dqs_o)
      else $error("strobes low on first beat");
   a_strobe_alt: assert property (!dqs_oe_n && !$past(dqs_oe_n) && $changed(dqs_o)
      |-> dqs_o == ~$past(dqs_o) ##1 $stable(dqs_o)[*3]) else $error("strobes not toggling");
   a_beat_hold: assert property (!dq_oe_n && $changed(dq_o) |=> $stable(dq_o)[*3])
      else $error("beat shorter than half a link clock");
   a_idle_quiet: assert property (dq_oe_n |-> dq_o == '0 && dqs_o == '0)
      else $error("data lanes active outside burst");
   a_ref_in_sref: assert property (ref_pulse |-> $past(self_ref))
      else $error("refresh outside self refresh");
   a_ref_spacing: assert property (ref_pulse |-> gap_reg >= REFI_CYC - 1)
      else $error("refresh slots too close");
   a_sref_entry: assert property ($rose(ck) && !cke && !cs_n && ca[2:0] == 3'h4
      && !self_ref |-> ##[1:8] self_ref) else $error("self refresh not entered");
endmodule // lpd_mrr_checker
bind lpd_mrr_core lpd_mrr_checker #(.DQ_W(DQ_W), .REFI_CYC(REFI_CYC)) u_chk (
   .clk(clk), .srst(srst), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca), .dq_o(dq_o),
   .dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n), .ref_pulse(ref_pulse),
   .self_ref(self_ref));
`default_nettype wire

/* File: testbench/lpd_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpd_consts.vh"
// ------------------------------------------
// memory controller on the command link
// ------------------------------------------
module lpd_ctl_model (
   // system
   input  wire        clk,
   // data from the device
   input  wire [15:0] dq_o,
   input  wire        dq_oe_n,
   input  wire [1:0]  dqs_o,
   // command and address link
   output logic       ck,
   output logic       cke,
   output logic       cs_n,
   output logic [9:0] ca
);
   logic [1:0] div_reg = 2'h0;
   initial begin
      ck = 1'b0;
      cke = 1'b1;
      cs_n = 1'b1;
      ca = 10'h000;
   end
   // link clock, toggles every four system clocks
   always @(negedge clk) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) ck <= ~ck;
   end
   // wait for a link edge, then a quarter link period
   task automatic half(input logic rise);
      if (rise) @(posedge ck);
      else @(negedge ck);
      repeat (2) @(negedge clk);
   endtask
   // one command, then nops with the released bus inverted; mode reads and mode writes are both sent through it
   task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic c_n, input logic k);
      half(1'b0);
      cs_n = c_n;
      cke = k;
      ca = r;
      half(1'b1);
      ca = f;
      half(1'b0);
      cs_n = 1'b1;
      ca = ~f;
      repeat (2) half(1'b0);
   endtask
   // mode read and capture of the four beats
   task automatic mrr(input logic [7:0] ma, output logic [15:0] d [4],
                      output logic [1:0] s [4], output logic ok);
      int n;
      n = 0;
      cmd({ma[7:2], `LPD_CMD_MRR}, {8'h00, ma[1:0]}, 1'b0, 1'b1);
      while (dq_oe_n !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      ok = (n < 100);
      @(negedge clk);
      // whole burst taken before anything else is sent
      for (int i = 0; i < 4; i++) begin
         d[i] = dq_o;
         s[i] = dqs_o;
         repeat (4) @(negedge clk);
      end
   endtask
endmodule // lpd_ctl_model
`default_nettype wire

/* File: testbench/tb_lpddr2_mode_read_pasr_temp.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpd_consts.vh"
module tb_lpddr2_mode_read_pasr_temp;
   logic        clk;
   logic        srst;
   logic        ce;
   logic [2:0]  temp_code;
   wire         ck;
   wire         cke;
   wire         cs_n;
   wire  [9:0]  ca;
   wire  [15:0] dq_o;
   wire         dq_oe_n;
   wire  [1:0]  dqs_o;
   wire         dqs_oe_n;
   wire         ref_pulse;
   wire  [2:0]  ref_bank;
   wire  [2:0]  ref_seg;
   wire         self_ref;
   wire         pwr_down;
   int          err_count = 0;
   int          tests_run = 0;
   int          pulses = 0;
   int          bad = 0;
   logic [7:0]  bmask = 8'h00;
   logic [7:0]  smask = 8'h00;
   logic [15:0] d [4];
   logic [1:0]  s [4];
   logic        ok;
   // ----------------------------------------
   // device, controller and clock
   // ----------------------------------------
   lpd_mrr_core #(.RL(4'h3), .DENSITY_MB(1024), .TSI_CYC(20'h007D0),
      .REFI_CYC(20'h00008)) DUT (.clk(clk), .srst(srst), .ce(ce), .ck(ck), .cke(cke),
      .cs_n(cs_n), .ca(ca), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o),
      .dqs_oe_n(dqs_oe_n), .temp_code(temp_code), .ref_pulse(ref_pulse),
      .ref_bank(ref_bank), .ref_seg(ref_seg), .self_ref(self_ref), .pwr_down(pwr_down));
   lpd_ctl_model ctl (.clk(clk), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .ck(ck),
      .cke(cke), .cs_n(cs_n), .ca(ca));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // count refresh slots, and those that hit a masked bank or segment
   always @(posedge clk) if (ref_pulse === 1'b1) begin
      pulses++;
      if (bmask[ref_bank] | smask[ref_seg]) bad++;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
         err_count++;
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rd(input logic [7:0] ma, input logic [15:0] e0, e1, e2, e3);
      logic [15:0] e [4];
      e = '{e0, e1, e2, e3};
      ctl.mrr(ma, d, s, ok);
      if (!ok) begin
         err_count++;
         final_report;
      end
      for (int i = 0; i < 4; i++) begin
         chk("read data", d[i], e[i]);
         chk("read strobe", {14'h0000, s[i]}, i[0] ? 16'h0000 : 16'h0003);
      end
      $display("test read %h done", ma);
   endtask
   task automatic wr(input logic [7:0] ma, input logic [7:0] v);
      ctl.cmd({ma[7:2], `LPD_CMD_MRW}, {v, ma[1:0]}, 1'b0, 1'b1);
   endtask
   // program masks, run one full slot sweep in self refresh, leave it
   task automatic sweep(input logic [7:0] bm, input logic [7:0] sm, input logic [15:0] n,
                        input logic clr);
      wr(`LPD_MA_BANK_MASK, bm);
      wr(`LPD_MA_SEG_MASK, sm);
      if (clr) wr(`LPD_MA_RESET, 8'h00);
      bmask = clr ? 8'h00 : bm;
      smask = clr ? 8'h00 : sm;
      ctl.cmd({7'h00, `LPD_CMD_SREF}, 10'h000, 1'b0, 1'b0);
      chk("self_ref", {15'h0000, self_ref}, 16'h0001);
      pulses = 0;
      bad = 0;
      repeat (512) @(negedge clk);
      chk("refresh count", pulses[15:0], n);
      chk("masked refresh", bad[15:0], 16'h0000);
      ctl.cmd(10'h000, 10'h000, 1'b1, 1'b1);
      chk("self_ref exit", {15'h0000, self_ref}, 16'h0000);
      $display("test sweep %h %h done", bm, sm);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      temp_code = 3'h5;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      rd(`LPD_MA_TEMP, 16'h0003, 16'h0000, 16'h0000, 16'h0000);
      temp_code = 3'h6;
      ctl.cmd(10'h000, 10'h000, 1'b1, 1'b0);
      chk("pwr_down", {15'h0000, pwr_down}, 16'h0001);
      ctl.cmd(10'h000, 10'h000, 1'b1, 1'b1);
      rd(`LPD_MA_TEMP, 16'h0006, 16'h0000, 16'h0000, 16'h0000);
      temp_code = 3'h1;
      repeat (2100) @(negedge clk);
      rd(`LPD_MA_TEMP, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
      // clock enable low freezes the sensor timer, so the old reading stays
      temp_code = 3'h2;
      ce = 1'b0;
      repeat (2100) @(negedge clk);
      ce = 1'b1;
      rd(`LPD_MA_TEMP, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
      rd(`LPD_MA_CAL_A, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000);
      rd(`LPD_MA_CAL_B, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF);
      rd(`LPD_MA_SEG_MASK, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      sweep(8'h82, 8'h84, 16'h0024, 1'b0);
      sweep(8'h00, 8'h0F, 16'h0020, 1'b0);
      sweep(8'hFF, 8'hFF, 16'h0040, 1'b1);
      final_report;
   end
endmodule // tb_lpddr2_mode_read_pasr_temp
`default_nettype wire
